//--- rtl/sensor_result_pkg.sv
// Package with register map, field layout and carrier types of the result bank
package sensor_result_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFF_MAKER_CODE_LOW = 8'h0e;
	localparam logic [7:0] OFF_MAKER_CODE_HIGH = 8'h0f;
	localparam logic [7:0] OFF_TEMP_RESULT_HIGH = 8'h10;
	localparam logic [7:0] OFF_TEMP_RESULT_LOW = 8'h11;
	localparam logic [7:0] OFF_XAXIS_RESULT_HIGH = 8'h12;
	localparam logic [7:0] OFF_XAXIS_RESULT_LOW = 8'h13;
	localparam logic [7:0] OFF_YAXIS_RESULT_HIGH = 8'h14;
	localparam logic [7:0] OFF_YAXIS_RESULT_LOW = 8'h15;
	localparam logic [7:0] OFF_ZAXIS_RESULT_HIGH = 8'h16;
	localparam logic [7:0] OFF_ZAXIS_RESULT_LOW = 8'h17;
	localparam logic [7:0] OFF_CONVERSION_STATE = 8'h18;
	localparam logic [7:0] OFF_ROTATION_HIGH = 8'h19;
	localparam logic [7:0] OFF_ROTATION_LOW = 8'h1a;
	localparam logic [7:0] OFF_FIELD_VECTOR_SIZE = 8'h1b;
	localparam logic [7:0] OFF_DEVICE_HEALTH = 8'h1c;

	// Arbitrary identification value, not tied to any maker
	localparam logic [15:0] MAKER_CODE_DEFAULT = 16'ha5c3;

	// Conversion state fields
	localparam int SET_COUNT_LSB = 5;
	localparam int SET_COUNT_W = 3;
	localparam int POWER_ON_BIT = 4;
	localparam int DIAG_BIT = 1;
	localparam int READY_BIT = 0;
	localparam logic [7:0] CONVERSION_STATE_RESET = 8'h10;

	// Device health fields
	localparam int PIN_LEVEL_BIT = 4;
	localparam int FAULT_W = 4;
	localparam logic [7:0] DEVICE_HEALTH_RESET = 8'h10;

	// Angle field layout
	localparam int ROTATION_W = 13;
	localparam int ROTATION_FRAC_W = 4;

	// Unmapped reads return this
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE
	} access_e;

	// Result set delivered by the conversion engine
	typedef struct packed {
		logic [15:0] temperatureValue;
		logic [15:0] xaxisValue;
		logic [15:0] yaxisValue;
		logic [15:0] zaxisValue;
		logic [15:0] rotation;
		logic [7:0] fieldVectorSize;
	} result_set_s;

	// Fault inputs: oscillator, irq pin, memory crc, supply low (bit 3 to 0)
	typedef struct packed {
		logic oscillatorFault;
		logic irqPinFault;
		logic memoryCrcFault;
		logic supplyLowFault;
	} fault_set_s;

	// Register access from the serial front end
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_access_s;

endpackage

//--- rtl/fault_sticky.sv
`timescale 1ns/1ps
// Sticky fault flags with write-one-to-clear, set winning over clear
module fault_sticky
	import sensor_result_pkg::*;
(
	// Clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Events and clear
	input wire logic [FAULT_W-1:0] setEvent,
	input wire logic [FAULT_W-1:0] clearMask,
	// Flags
	output logic [FAULT_W-1:0] flags
);

	logic [FAULT_W-1:0] next_flags;

	assign next_flags = (flags & ~clearMask) | setEvent;

	always_ff @(posedge mclk) begin
		if (rst) begin
			flags <= '0;
		end else if (ce) begin
			flags <= next_flags;
		end
	end

endmodule

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a group of asynchronous levels
module pin_sync #(
	parameter int W = 1
) (
	// Clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Levels
	input wire logic [W-1:0] async,
	output logic [W-1:0] synced
);

	logic [W-1:0] stage1;

	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1 <= '0;
			synced <= '0;
		end else if (ce) begin
			stage1 <= async;
			synced <= stage1;
		end
	end

endmodule

//--- rtl/sensor_result_status_regs.sv
`timescale 1ns/1ps
// Result and status register bank of a three-axis field sensor
module sensor_result_status_regs
	import sensor_result_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Register access from the serial front end
	input wire reg_access_s regAccess,
	output logic [7:0] rdata,
	output logic rdataValid,
	// Conversion engine
	input wire result_set_s resultSet,
	input wire logic setDone,
	input wire logic bufferReady,
	// Fault detectors and pin readback (asynchronous levels)
	input wire fault_set_s faultLevels,
	input wire logic irqPinLevel,
	// Status view
	output logic [7:0] conversionState,
	output logic [7:0] deviceHealth
);

	// Stored result set
	logic [15:0] temperatureValue;
	logic [15:0] xaxisValue;
	logic [15:0] yaxisValue;
	logic [15:0] zaxisValue;
	logic [15:0] rotation;
	logic [7:0] fieldVectorSize;
	logic [SET_COUNT_W-1:0] setCount;
	logic powerOnFlag;
	logic readyFlag;
	logic pinLevel;
	logic pinCaptured;
	logic pinWarm;
	logic [FAULT_W-1:0] faultFlags;
	logic [FAULT_W:0] syncedIn;
	access_e access;

	// Decoding
	wire logic writeHit = regAccess.write && !regAccess.read;
	wire logic statusWrite = writeHit && regAccess.addr == OFF_CONVERSION_STATE;
	wire logic healthWrite = writeHit && regAccess.addr == OFF_DEVICE_HEALTH;
	wire logic clearPowerOn = statusWrite && regAccess.wdata[POWER_ON_BIT];
	wire logic [FAULT_W-1:0] faultClear =
		healthWrite ? regAccess.wdata[FAULT_W-1:0] : '0;
	wire logic [FAULT_W-1:0] faultNow = syncedIn[FAULT_W-1:0];
	wire logic pinNow = syncedIn[FAULT_W];
	wire logic diagFail = |faultFlags;
	wire logic [15:0] angleMasked = {3'b000, rotation[ROTATION_W-1:0]};
	wire result_set_s heldSet =
		{temperatureValue, xaxisValue, yaxisValue, zaxisValue, angleMasked, fieldVectorSize};
	wire logic [7:0] readMux = decode(regAccess.addr, heldSet, conversionState, deviceHealth);
	wire logic [SET_COUNT_W-1:0] next_setCount = setCount + SET_COUNT_W'(1);

	assign access = regAccess.read ? ACC_READ : (regAccess.write ? ACC_WRITE : ACC_IDLE);

	assign conversionState = {setCount, powerOnFlag, 2'b00, diagFail, readyFlag};
	assign deviceHealth = {3'b000, pinLevel, faultFlags};

	// Every source is an argument, so the mux re-evaluates whenever any of them moves
	function automatic logic [7:0] decode(
		input logic [7:0] addr,
		input result_set_s held,
		input logic [7:0] statusByte,
		input logic [7:0] healthByte
	);
		logic [7:0] value;
		value = UNMAPPED_DATA;
		case (addr)
			OFF_MAKER_CODE_LOW: value = MAKER_CODE_DEFAULT[7:0];
			OFF_MAKER_CODE_HIGH: value = MAKER_CODE_DEFAULT[15:8];
			OFF_TEMP_RESULT_HIGH: value = held.temperatureValue[15:8];
			OFF_TEMP_RESULT_LOW: value = held.temperatureValue[7:0];
			OFF_XAXIS_RESULT_HIGH: value = held.xaxisValue[15:8];
			OFF_XAXIS_RESULT_LOW: value = held.xaxisValue[7:0];
			OFF_YAXIS_RESULT_HIGH: value = held.yaxisValue[15:8];
			OFF_YAXIS_RESULT_LOW: value = held.yaxisValue[7:0];
			OFF_ZAXIS_RESULT_HIGH: value = held.zaxisValue[15:8];
			OFF_ZAXIS_RESULT_LOW: value = held.zaxisValue[7:0];
			OFF_CONVERSION_STATE: value = statusByte;
			OFF_ROTATION_HIGH: value = held.rotation[15:8];
			OFF_ROTATION_LOW: value = held.rotation[7:0];
			OFF_FIELD_VECTOR_SIZE: value = held.fieldVectorSize;
			OFF_DEVICE_HEALTH: value = healthByte;
			default: value = UNMAPPED_DATA;
		endcase
		return value;
	endfunction

	// Synchronise fault levels and pin readback
	pin_sync #(
		.W(FAULT_W + 1)
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.async({irqPinLevel, faultLevels}),
		.synced(syncedIn)
	);

	// Sticky fault flags
	fault_sticky u_faults (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.setEvent(faultNow),
		.clearMask(faultClear),
		.flags(faultFlags)
	);

	// Result capture; host writes never reach these
	always_ff @(posedge mclk) begin
		if (rst) begin
			temperatureValue <= '0;
			xaxisValue <= '0;
			yaxisValue <= '0;
			zaxisValue <= '0;
			rotation <= '0;
			fieldVectorSize <= '0;
		end else if (ce && setDone) begin
			temperatureValue <= resultSet.temperatureValue;
			xaxisValue <= resultSet.xaxisValue;
			yaxisValue <= resultSet.yaxisValue;
			zaxisValue <= resultSet.zaxisValue;
			rotation <= resultSet.rotation;
			fieldVectorSize <= resultSet.fieldVectorSize;
		end
	end

	// Conversion status: counter, power-on flag, ready flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			setCount <= '0;
			powerOnFlag <= 1'b1;
			readyFlag <= 1'b0;
		end else if (ce) begin
			if (setDone) begin
				setCount <= next_setCount;
			end
			if (clearPowerOn) begin
				powerOnFlag <= 1'b0;
			end
			readyFlag <= bufferReady;
		end
	end

	// Pin readback: reads high from reset, tracks the pin once both sync stages hold it
	always_ff @(posedge mclk) begin
		if (rst) begin
			pinLevel <= 1'b1;
			pinCaptured <= 1'b0;
			pinWarm <= 1'b0;
		end else if (ce) begin
			pinCaptured <= 1'b1;
			pinWarm <= pinCaptured;
			if (pinWarm) begin
				pinLevel <= pinNow;
			end
		end
	end

	// Read data register
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata <= '0;
			rdataValid <= 1'b0;
		end else if (ce) begin
			rdataValid <= access == ACC_READ;
			if (access == ACC_READ) begin
				rdata <= readMux;
			end
		end
	end

endmodule

//--- tb/sensor_result_checker.sv
// Property checker of the result and status register bank
`timescale 1ns/1ps
module sensor_result_checker
	import sensor_result_pkg::*;
(
	// Clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Access
	input wire reg_access_s regAccess,
	input wire logic [7:0] rdata,
	input wire logic rdataValid,
	// Engine and status
	input wire logic setDone,
	input wire logic bufferReady,
	input wire logic [7:0] conversionState,
	input wire logic [7:0] deviceHealth
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic rd = ce && !rst && regAccess.read;
	wire logic wr = ce && !rst && regAccess.write && !regAccess.read;
	wire logic [7:0] ad = regAccess.addr;
	property p_rdStat;
		rd && ad == OFF_CONVERSION_STATE |=> rdataValid && rdata == $past(conversionState);
	endproperty
	a_rdStat: assert property (p_rdStat) else $error("bad status read");
	property p_rdHealth;
		rd && ad == OFF_DEVICE_HEALTH |=> rdataValid && rdata == $past(deviceHealth);
	endproperty
	a_rdHealth: assert property (p_rdHealth) else $error("bad health read");
	property p_maker;
		rd && ad == OFF_MAKER_CODE_HIGH |=> rdata == MAKER_CODE_DEFAULT[15:8];
	endproperty
	a_maker: assert property (p_maker) else $error("bad maker byte");
	property p_count;
		ce && !rst && setDone |=> conversionState[7:5] == $past(conversionState[7:5]) + 3'd1;
	endproperty
	a_count: assert property (p_count) else $error("count not advanced");
	property p_hold;
		ce && !rst && !setDone |=> $stable(conversionState[7:5]);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved");
	property p_freeze;
		!ce && !rst |=> $stable(conversionState) && $stable(deviceHealth);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
	property p_por;
		$fell(conversionState[4]) |-> $past(wr && ad == OFF_CONVERSION_STATE && regAccess.wdata[4]);
	endproperty
	a_por: assert property (p_por) else $error("power flag lost");
	property p_diag;
		conversionState[DIAG_BIT] == |deviceHealth[3:0];
	endproperty
	a_diag: assert property (p_diag) else $error("bad diag bit");
	property p_ready;
		ce && !rst |=> conversionState[READY_BIT] == $past(bufferReady);
	endproperty
	a_ready: assert property (p_ready) else $error("bad ready bit");
	property p_sticky;
		ce && !rst && !(wr && ad == OFF_DEVICE_HEALTH) |=>
			(deviceHealth[3:0] & $past(deviceHealth[3:0])) == $past(deviceHealth[3:0]);
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault flag lost");
endmodule
bind sensor_result_status_regs sensor_result_checker sensor_result_checker_inst (
	.mclk(mclk), .rst(rst), .ce(ce), .regAccess(regAccess), .rdata(rdata),
	.rdataValid(rdataValid), .setDone(setDone), .bufferReady(bufferReady),
	.conversionState(conversionState), .deviceHealth(deviceHealth)
);

//--- tb/host_model.sv
// Host model issuing register reads and writes
`timescale 1ns/1ps
module host_model
	import sensor_result_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Access
	output reg_access_s acc,
	input wire logic [7:0] rdata,
	input wire logic rdataValid
);
	initial acc = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) acc <= '{1'b0, 1'b1, a, d};
		@(posedge mclk) acc <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk) acc <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge mclk) acc <= '0;
		#1 d = rdataValid ? rdata : 8'hxx;
	endtask
endmodule

//--- tb/tb.sv
// Testbench of the result and status register bank
`timescale 1ns/1ps
module tb;
	import sensor_result_pkg::*;
	logic mclk = 0, rst = 1, ce = 1, setDone = 0, bufferReady = 0, irqPinLevel = 1;
	reg_access_s regAccess;
	result_set_s resultSet = '0;
	fault_set_s faultLevels = '0;
	logic [7:0] rdata, conversionState, deviceHealth, d;
	logic rdataValid;
	logic [7:0] offs[11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
		8'h19, 8'h1a, 8'h1b};
	logic [7:0] exps[11] = '{8'h11, 8'h08, 8'h22, 8'h08, 8'h33, 8'h08, 8'h44, 8'h08,
		8'h1f, 8'h08, 8'h58};
	int bad_count = 0, compares = 0;
	always #5 mclk = ~mclk;
	sensor_result_status_regs sensor_result_status_regs_inst (.mclk(mclk), .rst(rst),
		.ce(ce), .regAccess(regAccess), .rdata(rdata), .rdataValid(rdataValid),
		.resultSet(resultSet), .setDone(setDone), .bufferReady(bufferReady),
		.faultLevels(faultLevels), .irqPinLevel(irqPinLevel),
		.conversionState(conversionState), .deviceHealth(deviceHealth));
	host_model host_model_inst (.mclk(mclk), .acc(regAccess), .rdata(rdata),
		.rdataValid(rdataValid));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		host_model_inst.rd(a, d);
		check(d, exp);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		rdc(OFF_CONVERSION_STATE, 8'h10);
		rdc(OFF_DEVICE_HEALTH, 8'h10);
		rdc(OFF_MAKER_CODE_LOW, MAKER_CODE_DEFAULT[7:0]);
		rdc(OFF_MAKER_CODE_HIGH, MAKER_CODE_DEFAULT[15:8]);
		$display("test reset done");
		for (int i = 1; i <= 8; i++) begin
			@(posedge mclk) begin
				resultSet <= '{{8'h11, 8'(i)}, {8'h22, 8'(i)}, {8'h33, 8'(i)},
					{8'h44, 8'(i)}, {8'hff, 8'(i)}, 8'h50 + 8'(i)};
				setDone <= 1;
			end
			@(posedge mclk) setDone <= 0;
			rdc(OFF_CONVERSION_STATE, {3'(i), 5'h10});
		end
		foreach (offs[k]) rdc(offs[k], exps[k]);
		foreach (offs[k]) host_model_inst.wr(offs[k], 8'hff);
		host_model_inst.wr(OFF_MAKER_CODE_LOW, 8'h00);
		foreach (offs[k]) rdc(offs[k], exps[k]);
		rdc(OFF_MAKER_CODE_LOW, MAKER_CODE_DEFAULT[7:0]);
		$display("test results done");
		@(posedge mclk) begin
			ce <= 0;
			resultSet <= '{16'h9999, 16'h9999, 16'h9999, 16'h9999, 16'h9999, 8'h99};
			setDone <= 1;
		end
		@(posedge mclk) setDone <= 0;
		@(posedge mclk) ce <= 1;
		rdc(OFF_CONVERSION_STATE, 8'h10);
		rdc(OFF_TEMP_RESULT_HIGH, 8'h11);
		host_model_inst.wr(OFF_CONVERSION_STATE, 8'h10);
		rdc(OFF_CONVERSION_STATE, 8'h00);
		@(posedge mclk) rst <= 1;
		repeat (2) @(posedge mclk);
		rst <= 0;
		rdc(OFF_TEMP_RESULT_HIGH, 8'h00);
		rdc(OFF_CONVERSION_STATE, 8'h10);
		rdc(OFF_DEVICE_HEALTH, 8'h10);
		$display("test freeze and reset done");
		@(posedge mclk) bufferReady <= 1;
		host_model_inst.wr(OFF_CONVERSION_STATE, 8'h10);
		rdc(OFF_CONVERSION_STATE, 8'h01);
		@(posedge mclk) faultLevels <= '{1'b1, 1'b0, 1'b1, 1'b0};
		repeat (4) @(posedge mclk);
		faultLevels <= '0;
		rdc(OFF_CONVERSION_STATE, 8'h03);
		rdc(OFF_DEVICE_HEALTH, 8'h1a);
		host_model_inst.wr(OFF_DEVICE_HEALTH, 8'h08);
		rdc(OFF_DEVICE_HEALTH, 8'h12);
		host_model_inst.wr(OFF_DEVICE_HEALTH, 8'h02);
		irqPinLevel <= 0;
		rdc(OFF_CONVERSION_STATE, 8'h01);
		repeat (4) @(posedge mclk);
		rdc(OFF_DEVICE_HEALTH, 8'h00);
		@(posedge mclk) faultLevels <= '{1'b0, 1'b0, 1'b0, 1'b1};
		repeat (4) @(posedge mclk);
		faultLevels <= '0;
		rdc(OFF_DEVICE_HEALTH, 8'h01);
		$display("test status done");
		end_sim();
	end
	initial begin
		#20000;
		bad_count++;
		end_sim();
	end
endmodule
